/* rtl/msc_defines.vh */
// Constants for the microstep sequencer control core.
// Assumes inclusion by the design file only; no logic lives here.
`ifndef MSC_DEFINES_VH
`define MSC_DEFINES_VH

// Serial command word layout
`define MSC_WORD_BITS 16
`define MSC_WORD_ADDR_MSB 15
`define MSC_WORD_ADDR_LSB 13
`define MSC_WORD_DATA_MSB 12
`define MSC_CMD_COUNT 6
`define MSC_CMD_LAST 3'h5

// Command addresses
`define MSC_CMD_START_WAIT 0
`define MSC_CMD_EXC_WAIT 1
`define MSC_CMD_MODE 2
`define MSC_CMD_PULSE_CYCLE 3
`define MSC_CMD_PULSE_COUNT 4
`define MSC_CMD_SCALE 5

// Fields of the mode command
`define MSC_MODE_TWO_PHASE_BIT 0
`define MSC_MODE_DIR_BIT 1
`define MSC_MODE_CUR_LSB 2
`define MSC_MODE_CUR_MSB 5
// Fields of the scale command
`define MSC_SCALE_MULT_LSB 0
`define MSC_SCALE_MULT_MSB 2
`define MSC_SCALE_CHOP_LSB 3
`define MSC_SCALE_CHOP_MSB 12

// Step table
`define MSC_STEP_ONE 6'h01
`define MSC_STEP_QUAD 6'h10
`define MSC_QUAD_MASK 6'h30
`define MSC_FULL_SCALE 10'h3E8

// Register bus map (byte addresses)
`define MSC_REG_STATUS 8'h00
`define MSC_REG_POSITION 8'h04
`define MSC_REG_CTRL 8'h08
`define MSC_REG_CMD_BASE 8'h10
`define MSC_CTRL_HALT_BIT 0
`define MSC_CTRL_RESET 1'h0

// Sequencer states
`define MSC_ST_IDLE 2'h0
`define MSC_ST_WAIT_START 2'h1
`define MSC_ST_WAIT_EXC 2'h2
`define MSC_ST_RUN 2'h3

// Pin synchroniser width
`define MSC_SYNC_BITS 8

`endif

/* rtl/msc_top.v */
// Control core of a two-channel microstep driver: serial command link,
// step sequencer, current reference synthesis, PWM chopping, AHB-Lite status.
// Assumes pins arrive asynchronous to sys_clk_i and an analog comparator
// reports, per bridge, when sensed current exceeds the reference level.
`timescale 1ns/1ps
`include "msc_defines.vh"

// What this block does
// - One electrical cycle is split into 64 current steps, one per pulse in microstep mode.
// - Each step adds 5.625 degrees; sixteen steps make a quarter cycle.
// - Phase current follows typical table levels 0, 9.8, 19.5 ... 70.7 ... 100.
// - Two-phase mode drives plus or minus full scale on both bridges.
// - Microstep or two-phase mode is chosen only by a serial command.
// - Each bridge is chopped by comparing sensed current with the step reference.
// - Commands set waits, chopping, current, direction, mode, pulse cycle and count.
// - Each command has its own address; unwritten addresses keep contents.
// - Reset pin low clears registers, halts logic, floats both bridges.
// - After reset excitation starts at bridge one +100%, bridge two 0%.
// - Two-phase after reset starts with both bridges at positive full current.
// - Phase marker stays low after reset until the first step pulse.
// - Start wait then excitation wait complete before any step pulse.
// - Enable low floats the bridges at once and enters standby.
// - Pending pulses resume from the kept position when enable returns.
// - Standby keeps all command contents and the excitation position.
// - Stopped reference clock freezes logic while excitation continues.
// - Reference clock back with enable low keeps standby.
// - Serial word is 16 bits LSB first: 3 address bits over 13 data bits.
// - Data sampled on serial clock rise with latch high; applied at latch fall.
// - Phase marker floats during reset and standby.
// - Serial words received during reset or standby are discarded.
module msc_top
(
  input wire sys_clk_i,
  input wire rst_i,
  // AHB-Lite slave
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output wire [31:0] hrdata_o,
  output wire hreadyout_o,
  output wire hresp_o,
  // Device pins
  input wire reset_low_pin_i,
  input wire enable_pin_i,
  input wire reference_clock_in_i,
  input wire serial_clock_i,
  input wire latch_i,
  input wire serial_data_in_i,
  input wire [1:0] sense_over_i,
  output wire bridge_one_fwd_o,
  output wire bridge_one_rev_o,
  output wire bridge_one_oe_o,
  output wire bridge_two_fwd_o,
  output wire bridge_two_rev_o,
  output wire bridge_two_oe_o,
  output wire phase_marker_out_o,
  output wire phase_marker_out_oe_o,
  output wire [9:0] ref_one_o,
  output wire [9:0] ref_two_o
);

  // Typical quarter-cycle current table in tenths of a percent
  function [9:0] quarter_level;
    input [4:0] k;
    begin
      case (k)
        5'h00: quarter_level = 10'h000;
        5'h01: quarter_level = 10'h062;
        5'h02: quarter_level = 10'h0C3;
        5'h03: quarter_level = 10'h122;
        5'h04: quarter_level = 10'h17F;
        5'h05: quarter_level = 10'h1D7;
        5'h06: quarter_level = 10'h22C;
        5'h07: quarter_level = 10'h27A;
        5'h08: quarter_level = 10'h2C3;
        5'h09: quarter_level = 10'h305;
        5'h0A: quarter_level = 10'h33F;
        5'h0B: quarter_level = 10'h372;
        5'h0C: quarter_level = 10'h39C;
        5'h0D: quarter_level = 10'h3BD;
        5'h0E: quarter_level = 10'h3D5;
        default: quarter_level = `MSC_FULL_SCALE;
      endcase
    end
  endfunction

  // Pin synchronisers; stage one feeds stage two only
  wire [`MSC_SYNC_BITS-1:0] pins_raw;
  reg [`MSC_SYNC_BITS-1:0] sync1_q;
  reg [`MSC_SYNC_BITS-1:0] sync2_q;
  reg [`MSC_SYNC_BITS-1:0] sync3_q;
  assign pins_raw = {sense_over_i, serial_data_in_i, latch_i, serial_clock_i,
                     reference_clock_in_i, enable_pin_i, reset_low_pin_i};
  genvar gi;
  generate
    for (gi = 0; gi < `MSC_SYNC_BITS; gi = gi + 1)
    begin : g_sync
      always @(posedge sys_clk_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          sync1_q[gi] <= 1'h0;
          sync2_q[gi] <= 1'h0;
          sync3_q[gi] <= 1'h0;
        end
        else
        begin
          sync1_q[gi] <= pins_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
        end
      end
    end
  endgenerate

  wire pin_run = sync2_q[0];
  wire en_s = sync2_q[1];
  wire ref_rise = sync2_q[2] & ~sync3_q[2];
  wire sclk_rise = sync2_q[3] & ~sync3_q[3];
  wire latch_s = sync2_q[4];
  wire latch_fall = ~sync2_q[4] & sync3_q[4];
  wire serial_data_in_s = sync2_q[5];
  wire [1:0] over_s = sync2_q[7:6];

  // State
  reg [15:0] shift_q;
  reg [3:0] bit_cnt_q;
  reg [77:0] cmd_q;
  reg [77:0] pend_q;
  reg [5:0] pend_v_q;
  reg [1:0] state_q;
  reg [12:0] tick_cnt_q;
  reg [19:0] pulses_left_q;
  reg [5:0] step_idx_q;
  reg excited_q;
  reg first_pulse_q;
  reg ctrl_halt_q;

  // Command fields
  wire [12:0] start_wait = cmd_q[`MSC_CMD_START_WAIT*13 +: 13];
  wire [12:0] exc_wait = cmd_q[`MSC_CMD_EXC_WAIT*13 +: 13];
  wire [12:0] mode_word = cmd_q[`MSC_CMD_MODE*13 +: 13];
  wire [12:0] pulse_cycle = cmd_q[`MSC_CMD_PULSE_CYCLE*13 +: 13];
  wire [12:0] scale_word = cmd_q[`MSC_CMD_SCALE*13 +: 13];
  wire two_phase = mode_word[`MSC_MODE_TWO_PHASE_BIT];
  wire dir_down = mode_word[`MSC_MODE_DIR_BIT];
  wire [3:0] cur_sel = mode_word[`MSC_MODE_CUR_MSB:`MSC_MODE_CUR_LSB];
  wire [2:0] mult_sel = scale_word[`MSC_SCALE_MULT_MSB:`MSC_SCALE_MULT_LSB];
  wire [9:0] chop_period = scale_word[`MSC_SCALE_CHOP_MSB:`MSC_SCALE_CHOP_LSB];

  // Link is deaf in reset, standby and the two start waits
  wire in_wait = (state_q == `MSC_ST_WAIT_START) || (state_q == `MSC_ST_WAIT_EXC);
  wire link_ok = pin_run & en_s & ~in_wait;
  wire [15:0] word_in = {serial_data_in_s, shift_q[15:1]};
  wire [2:0] word_addr = word_in[`MSC_WORD_ADDR_MSB:`MSC_WORD_ADDR_LSB];
  wire word_done = sclk_rise & latch_s & (bit_cnt_q == 4'hF);
  wire commit = latch_fall & link_ok & (pend_v_q != 6'h00);
  wire launch = commit & pend_v_q[`MSC_CMD_PULSE_COUNT];
  wire [12:0] new_mode = pend_q[`MSC_CMD_MODE*13 +: 13];
  wire [12:0] new_count = pend_q[`MSC_CMD_PULSE_COUNT*13 +: 13];
  wire [2:0] new_mult = pend_v_q[`MSC_CMD_SCALE] ?
    pend_q[`MSC_CMD_SCALE*13 + `MSC_SCALE_MULT_LSB +: 3] : mult_sel;

  // Serial shifter and per-address staging; partial words are dropped
  integer k;
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      shift_q <= 16'h0000;
      bit_cnt_q <= 4'h0;
      pend_q <= 78'h0;
      pend_v_q <= 6'h00;
      cmd_q <= 78'h0;
    end
    else if (!pin_run)
    begin
      shift_q <= 16'h0000;
      bit_cnt_q <= 4'h0;
      pend_q <= 78'h0;
      pend_v_q <= 6'h00;
      cmd_q <= 78'h0;
    end
    else
    begin
      if (!latch_s)
        bit_cnt_q <= 4'h0;
      else if (sclk_rise)
      begin
        shift_q <= word_in;
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
      // Last word per address wins within one latch window
      for (k = 0; k < `MSC_CMD_COUNT; k = k + 1)
      begin
        if (latch_fall)
          pend_v_q[k] <= 1'b0;
        else if (word_done && link_ok && (word_addr == k[2:0]))
        begin
          pend_v_q[k] <= 1'b1;
          pend_q[k*13 +: 13] <= word_in[`MSC_WORD_DATA_MSB:0];
        end
        if (commit && pend_v_q[k])
          cmd_q[k*13 +: 13] <= pend_q[k*13 +: 13];
      end
    end
  end

  // Step sequencer, timed by reference clock edges only
  wire run_ok = en_s & ~ctrl_halt_q;
  wire [12:0] cycle_min = (pulse_cycle == 13'h0000) ? 13'h0001 : pulse_cycle;
  wire [5:0] step_delta = two_phase ? `MSC_STEP_QUAD : `MSC_STEP_ONE;
  wire [19:0] launch_pulses = {7'h00, new_count} << new_mult;
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= `MSC_ST_IDLE;
      tick_cnt_q <= 13'h0000;
      pulses_left_q <= 20'h00000;
      step_idx_q <= 6'h00;
      excited_q <= 1'b0;
      first_pulse_q <= 1'b0;
    end
    else if (!pin_run)
    begin
      state_q <= `MSC_ST_IDLE;
      tick_cnt_q <= 13'h0000;
      pulses_left_q <= 20'h00000;
      step_idx_q <= 6'h00;
      excited_q <= 1'b0;
      first_pulse_q <= 1'b0;
    end
    else if (launch)
    begin
      state_q <= `MSC_ST_WAIT_START;
      tick_cnt_q <= 13'h0000;
      pulses_left_q <= launch_pulses;
      if (pend_v_q[`MSC_CMD_MODE] && new_mode[`MSC_MODE_TWO_PHASE_BIT])
        step_idx_q <= step_idx_q & `MSC_QUAD_MASK;
    end
    else
    begin
      if (commit && pend_v_q[`MSC_CMD_MODE] && new_mode[`MSC_MODE_TWO_PHASE_BIT])
        step_idx_q <= step_idx_q & `MSC_QUAD_MASK;
      // No reference edges means no progress: logic freezes in place
      if (ref_rise && run_ok)
      begin
        case (state_q)
          `MSC_ST_WAIT_START:
          begin
            if (tick_cnt_q >= start_wait)
            begin
              state_q <= `MSC_ST_WAIT_EXC;
              tick_cnt_q <= 13'h0000;
              excited_q <= 1'b1;
            end
            else
              tick_cnt_q <= tick_cnt_q + 13'h0001;
          end
          `MSC_ST_WAIT_EXC:
          begin
            if (tick_cnt_q >= exc_wait)
            begin
              state_q <= `MSC_ST_RUN;
              tick_cnt_q <= 13'h0000;
            end
            else
              tick_cnt_q <= tick_cnt_q + 13'h0001;
          end
          `MSC_ST_RUN:
          begin
            if (pulses_left_q == 20'h00000)
              state_q <= `MSC_ST_IDLE;
            else if (tick_cnt_q + 13'h0001 >= cycle_min)
            begin
              tick_cnt_q <= 13'h0000;
              pulses_left_q <= pulses_left_q - 20'h00001;
              first_pulse_q <= 1'b1;
              if (dir_down)
                step_idx_q <= step_idx_q - step_delta;
              else
                step_idx_q <= step_idx_q + step_delta;
            end
            else
              tick_cnt_q <= tick_cnt_q + 13'h0001;
          end
          default:
            tick_cnt_q <= 13'h0000;
        endcase
      end
    end
  end

  // Current targets from quadrant and position in it
  wire [1:0] quad = step_idx_q[5:4];
  wire [4:0] pos = {1'b0, step_idx_q[3:0]};
  wire [9:0] lvl_up = quarter_level(pos);
  wire [9:0] lvl_dn = quarter_level(5'h10 - pos);
  reg [9:0] mag_one;
  reg [9:0] mag_two;
  reg neg_one;
  reg neg_two;
  always @*
  begin
    neg_one = quad[0] ^ quad[1];
    neg_two = quad[1];
    mag_one = quad[0] ? lvl_up : lvl_dn;
    mag_two = quad[0] ? lvl_dn : lvl_up;
    if (two_phase)
    begin
      mag_one = `MSC_FULL_SCALE;
      mag_two = `MSC_FULL_SCALE;
      neg_one = quad[0];
      neg_two = quad[1];
    end
  end

  // Scale by programmed motor current, (cur+1)/16 of table level
  wire [13:0] scaled_one = mag_one * ({1'b0, cur_sel} + 5'h01);
  wire [13:0] scaled_two = mag_two * ({1'b0, cur_sel} + 5'h01);

  // Peak-current chopping: turn on each period, cut when sense exceeds reference
  reg [9:0] chop_cnt_q;
  reg [1:0] chop_on_q;
  reg [9:0] ref_one_q;
  reg [9:0] ref_two_q;
  reg [5:0] bridge_q;
  reg marker_q;
  reg marker_oe_q;
  wire chop_wrap = (chop_cnt_q >= chop_period);
  wire drive_en = pin_run & en_s & excited_q;
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      chop_cnt_q <= 10'h000;
      chop_on_q <= 2'h0;
      ref_one_q <= 10'h000;
      ref_two_q <= 10'h000;
      bridge_q <= 6'h00;
      marker_q <= 1'b0;
      marker_oe_q <= 1'b0;
    end
    else
    begin
      chop_cnt_q <= chop_wrap ? 10'h000 : chop_cnt_q + 10'h001;
      ref_one_q <= scaled_one[13:4];
      ref_two_q <= scaled_two[13:4];
      if (chop_wrap)
        chop_on_q <= {ref_two_q != 10'h000, ref_one_q != 10'h000};
      else
        chop_on_q <= chop_on_q & ~over_s;
      // Off-time is slow decay with the bridge still enabled
      bridge_q <= {drive_en, drive_en & chop_on_q[1] & neg_two,
                   drive_en & chop_on_q[1] & ~neg_two,
                   drive_en, drive_en & chop_on_q[0] & neg_one,
                   drive_en & chop_on_q[0] & ~neg_one};
      marker_oe_q <= pin_run & en_s;
      if (!first_pulse_q)
        marker_q <= 1'b0;
      else if (two_phase)
        marker_q <= (quad != 2'h0);
      else
        marker_q <= (step_idx_q != 6'h00);
    end
  end

  // AHB-Lite slave: zero wait, always OKAY, reads registered
  reg hready_q;
  reg [31:0] hrdata_q;
  reg wr_pend_q;
  reg [7:0] wr_addr_q;
  wire addr_take = hsel_i & hready_i & htrans_i[1];
  wire [7:0] cmd_off = haddr_i[7:0] - `MSC_REG_CMD_BASE;
  reg [31:0] rd_mux;
  always @*
  begin
    rd_mux = 32'h00000000;
    if (haddr_i[7:0] == `MSC_REG_STATUS)
      rd_mux = {24'h000000, marker_q, first_pulse_q, excited_q, en_s, pin_run,
                ctrl_halt_q, state_q};
    else if (haddr_i[7:0] == `MSC_REG_POSITION)
      rd_mux = {4'h0, pulses_left_q, 2'h0, step_idx_q};
    else if (haddr_i[7:0] == `MSC_REG_CTRL)
      rd_mux = {31'h00000000, ctrl_halt_q};
    else if ((haddr_i[7:0] >= `MSC_REG_CMD_BASE) && (cmd_off[7:2] <= 6'h05) &&
             (cmd_off[1:0] == 2'h0))
      rd_mux = {19'h00000, cmd_q[cmd_off[4:2]*13 +: 13]};
  end

  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hready_q <= 1'b0;
      hrdata_q <= 32'h00000000;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      ctrl_halt_q <= `MSC_CTRL_RESET;
    end
    else
    begin
      hready_q <= 1'b1;
      wr_pend_q <= addr_take & hwrite_i;
      if (addr_take)
        wr_addr_q <= haddr_i[7:0];
      if (addr_take && !hwrite_i)
        hrdata_q <= rd_mux;
      if (wr_pend_q && (wr_addr_q == `MSC_REG_CTRL))
        ctrl_halt_q <= hwdata_i[`MSC_CTRL_HALT_BIT];
    end
  end

  assign hrdata_o = hrdata_q;
  assign hreadyout_o = hready_q;
  assign hresp_o = 1'b0;
  assign bridge_one_fwd_o = bridge_q[0];
  assign bridge_one_rev_o = bridge_q[1];
  assign bridge_one_oe_o = bridge_q[2];
  assign bridge_two_fwd_o = bridge_q[3];
  assign bridge_two_rev_o = bridge_q[4];
  assign bridge_two_oe_o = bridge_q[5];
  assign phase_marker_out_o = marker_q;
  assign phase_marker_out_oe_o = marker_oe_q;
  assign ref_one_o = ref_one_q;
  assign ref_two_o = ref_two_q;

endmodule // msc_top

/* testbench/msc_host_model.sv */
// Host side of the serial command link: 16-bit words, bit 0 first.
// Assumes the bench calls it while enable is high, save on purpose.
`timescale 1ns/1ps
module msc_host_model
(
  output reg serial_clock_o,
  output reg latch_o,
  output reg serial_data_o
);
  // Link idle: clock still, latch low
  initial
  begin
    serial_clock_o = 1'b0;
    latch_o = 1'b0;
    serial_data_o = 1'b0;
  end
  // Words only shift while the latch is high
  task open_win;
    begin
      latch_o = 1'b1;
      #400;
    end
  endtask
  // Data set a half period before each rising clock and held after it
  task word(input [2:0] a, input [12:0] d, input integer nb);
    reg [15:0] w;
    integer i;
    begin
      w = {a, d};
      for (i = 0; i < nb; i++)
      begin
        serial_data_o = w[i];
        #400 serial_clock_o = 1'b1;
        #400 serial_clock_o = 1'b0;
      end
    end
  endtask
  // Latch fall applies; data line left inverted so no stale level lingers
  task close_win;
    begin
      #400 latch_o = 1'b0;
      serial_data_o = ~serial_data_o;
    end
  endtask
endmodule // msc_host_model

/* testbench/msc_top_properties.sv */
// Checker for msc_top: float, chop and freeze relations at the pins.
// Assumes it is bound to msc_top and sees only its ports.
`timescale 1ns/1ps
module msc_top_properties
(
  input wire sys_clk_i,
  input wire rst_i,
  input wire reset_low_pin_i,
  input wire enable_pin_i,
  input wire reference_clock_in_i,
  input wire latch_i,
  input wire [1:0] sense_over_i,
  input wire bridge_one_fwd_o,
  input wire bridge_one_rev_o,
  input wire bridge_one_oe_o,
  input wire bridge_two_fwd_o,
  input wire bridge_two_rev_o,
  input wire bridge_two_oe_o,
  input wire phase_marker_out_oe_o,
  input wire [9:0] ref_one_o,
  input wire [9:0] ref_two_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  // Pin levels held long enough to cross the synchronisers
  sequence s_pin_low;
    !reset_low_pin_i [*5];
  endsequence
  sequence s_en_low;
    !enable_pin_i [*5];
  endsequence
  // No reference edge, no latch fall: nothing may move the targets
  sequence s_quiet;
    ($stable(reference_clock_in_i) && $stable(latch_i) && $stable(reset_low_pin_i)
      && $stable(enable_pin_i)) [*8];
  endsequence

  a_reset_floats: assert property (s_pin_low |-> !bridge_one_oe_o && !bridge_two_oe_o)
    else $error("bridge driven in reset");
  a_reset_marker: assert property (s_pin_low |-> !phase_marker_out_oe_o)
    else $error("marker driven in reset");
  a_standby_floats: assert property (s_en_low |-> !bridge_one_oe_o && !bridge_two_oe_o)
    else $error("bridge driven in standby");
  a_standby_marker: assert property (s_en_low |-> !phase_marker_out_oe_o)
    else $error("marker driven in standby");
  // Comparator high allows at most the single cycle of a period start
  a_chop_one: assert property (sense_over_i[0] [*5] |->
    !(bridge_one_fwd_o && $past(bridge_one_fwd_o))
    && !(bridge_one_rev_o && $past(bridge_one_rev_o)))
    else $error("bridge one not chopped");
  a_chop_two: assert property (sense_over_i[1] [*5] |->
    !(bridge_two_fwd_o && $past(bridge_two_fwd_o))
    && !(bridge_two_rev_o && $past(bridge_two_rev_o)))
    else $error("bridge two not chopped");
  a_no_short: assert property (!(bridge_one_fwd_o && bridge_one_rev_o)
    && !(bridge_two_fwd_o && bridge_two_rev_o)) else $error("both directions on");
  a_start_pos: assert property ($rose(reset_low_pin_i) |-> ##6 ref_two_o == 10'h000)
    else $error("bridge two not at zero after reset");
  a_frozen_ref: assert property (s_quiet |=> $stable(ref_one_o) && $stable(ref_two_o))
    else $error("targets moved without clock");
endmodule // msc_top_properties

/* testbench/tb_top.sv */
// Testbench for msc_top: AHB-Lite master, device pins and scenarios.
// Assumes the host model drives the serial pins of the block.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  reg sys_clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg ref_clk = 1'b0;
  reg ref_run = 1'b1;
  reg pin_n = 1'b0;
  reg en_pin = 1'b1;
  reg hsel = 1'b0;
  reg hwrite = 1'b0;
  reg [1:0] htrans = 2'h0;
  reg [31:0] haddr = 32'h0;
  reg [31:0] hwdata = 32'h0;
  reg [1:0] sense = 2'h0;
  reg [31:0] rd;
  reg [31:0] p0;
  reg [12:0] cv [0:5];
  reg seen;
  wire [31:0] hrdata;
  wire hready, hresp, sclk, latch, serial_data_in;
  wire b1f, b1r, b1e, b2f, b2r, b2e, mk, mke;
  wire [9:0] r1, r2;
  integer err_total = 0;
  integer compares = 0;
  integer k;

  // 10 MHz system clock; reference clock can be stopped
  always #50 sys_clk_i = ~sys_clk_i;
  always #400 ref_clk = ref_run ? ~ref_clk : ref_clk;

  msc_top dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .reset_low_pin_i(pin_n), .enable_pin_i(en_pin), .reference_clock_in_i(ref_clk),
    .serial_clock_i(sclk), .latch_i(latch), .serial_data_in_i(serial_data_in), .sense_over_i(sense),
    .bridge_one_fwd_o(b1f), .bridge_one_rev_o(b1r), .bridge_one_oe_o(b1e),
    .bridge_two_fwd_o(b2f), .bridge_two_rev_o(b2r), .bridge_two_oe_o(b2e),
    .phase_marker_out_o(mk), .phase_marker_out_oe_o(mke), .ref_one_o(r1), .ref_two_o(r2));
  msc_host_model host (.serial_clock_o(sclk), .latch_o(latch), .serial_data_o(serial_data_in));

  // Single word transfer: address phase, then data phase, each until hready
  task ahb(input w, input [31:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge sys_clk_i);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge sys_clk_i);
      for (n = 0; n < 50 && hready !== 1'b1; n++) @(posedge sys_clk_i);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge sys_clk_i);
      for (n = 0; n < 50 && hready !== 1'b1; n++) @(posedge sys_clk_i);
      if (hready !== 1'b1) err_total++;
      rd = hrdata;
    end
  endtask
  task rdr(input [31:0] a);
    ahb(1'b0, a, 32'h0);
  endtask
  // One word in its own window, then time for the latch fall to land
  task send(input [2:0] a, input [12:0] d);
    begin
      host.open_win;
      host.word(a, d, 16);
      host.close_win;
      repeat (8) @(posedge sys_clk_i);
    end
  endtask
  // Poll status until the sequencer is idle; words sent in either start wait would be dropped
  task idle;
    integer n;
    begin
      rd = 32'h1;
      for (n = 0; n < 2000 && rd[1:0] !== 2'h0; n++) rdr(32'h0);
      // A sequencer that never settles counts as a mismatch
      if (rd[1:0] !== 2'h0) err_total++;
    end
  endtask
  task chk_cmds;
    for (k = 0; k < 6; k++)
    begin
      rdr(32'h10 + 4 * k);
      `CHK(rd[12:0], cv[k])
    end
  endtask

  task t_reset;
    begin
      for (k = 0; k < 6; k++)
        cv[k] = 13'h0000;
      chk_cmds;
      rdr(32'h4);
      `CHK(rd[5:0], 6'h00)
      `CHK(r2, 10'h000)
      `CHK(mk, 1'b0)
      rdr(32'h80);
      `CHK(rd, 32'h0000_0000)
    end
  endtask
  task t_cmds;
    begin
      cv[0] = 13'h0003;
      cv[1] = 13'h0001;
      cv[2] = 13'h003C;
      cv[3] = 13'h0001;
      cv[4] = 13'h0000;
      cv[5] = 13'h00A0;
      host.open_win;
      for (k = 0; k < 6; k++)
        host.word(k[2:0], cv[k], 16);
      host.word(3'h0, 13'h1FFF, 8);
      host.close_win;
      repeat (8) @(posedge sys_clk_i);
      idle;
      chk_cmds;
      // Staged word must wait for the latch fall
      host.open_win;
      host.word(3'h1, 13'h0002, 16);
      rdr(32'h14);
      `CHK(rd[12:0], 13'h0001)
      host.close_win;
      cv[1] = 13'h0002;
      repeat (8) @(posedge sys_clk_i);
      chk_cmds;
    end
  endtask
  task t_move;
    begin
      send(3'h4, 13'h0005);
      rdr(32'h0);
      `CHK(rd[1:0], 2'h1)
      rdr(32'h4);
      `CHK(rd[5:0], 6'h00)
      idle;
      rdr(32'h4);
      `CHK(rd[5:0], 6'h05)
      `CHK(rd[27:8], 20'h00000)
      `CHK(r1, 10'h372)
      `CHK(r2, 10'h1D7)
      `CHK(mk, 1'b1)
      send(3'h2, 13'h003E);
      send(3'h4, 13'h0006);
      idle;
      rdr(32'h4);
      `CHK(rd[5:0], 6'h3F)
      send(3'h2, 13'h003C);
      send(3'h4, 13'h0001);
      idle;
      `CHK(r1, 10'h3E8)
      `CHK(mk, 1'b0)
      send(3'h4, 13'h0040);
      idle;
      rdr(32'h4);
      `CHK(rd[5:0], 6'h00)
    end
  endtask
  task t_two;
    begin
      send(3'h2, 13'h003D);
      `CHK(r1, 10'h3E8)
      `CHK(r2, 10'h3E8)
      send(3'h4, 13'h0001);
      idle;
      rdr(32'h4);
      `CHK(rd[5:0], 6'h10)
      `CHK(r1, 10'h3E8)
      `CHK(r2, 10'h3E8)
      send(3'h2, 13'h003C);
      `CHK(r1, 10'h000)
      `CHK(r2, 10'h3E8)
    end
  endtask
  task t_stby;
    begin
      send(3'h4, 13'h0014);
      repeat (100) @(posedge sys_clk_i);
      en_pin <= 1'b0;
      repeat (6) @(posedge sys_clk_i);
      `CHK(b1e, 1'b0)
      `CHK(b2e, 1'b0)
      `CHK(mke, 1'b0)
      rdr(32'h4);
      p0 = rd;
      // Sent in standby on purpose: must be dropped
      send(3'h0, 13'h0007);
      repeat (100) @(posedge sys_clk_i);
      rdr(32'h4);
      `CHK(rd, p0)
      rdr(32'h10);
      `CHK(rd[12:0], 13'h0003)
      en_pin <= 1'b1;
      idle;
      rdr(32'h4);
      `CHK(rd[5:0], 6'h24)
    end
  endtask
  task t_clkstop;
    begin
      send(3'h4, 13'h0014);
      repeat (100) @(posedge sys_clk_i);
      ref_run <= 1'b0;
      repeat (20) @(posedge sys_clk_i);
      rdr(32'h4);
      p0 = rd;
      ahb(1'b1, 32'h8, 32'h1);
      ahb(1'b1, 32'h8, 32'h0);
      repeat (100) @(posedge sys_clk_i);
      rdr(32'h4);
      `CHK(rd, p0)
      `CHK(b1e, 1'b1)
      ref_run <= 1'b1;
      idle;
      rdr(32'h4);
      `CHK(rd[5:0], 6'h38)
    end
  endtask
  task t_chop;
    begin
      seen = 1'b0;
      repeat (60) @(posedge sys_clk_i) seen = seen | b1f | b1r;
      `CHK(seen, 1'b1)
      sense <= 2'h3;
      repeat (60) @(posedge sys_clk_i);
      sense <= 2'h0;
    end
  endtask
  task t_pin;
    begin
      pin_n <= 1'b0;
      repeat (6) @(posedge sys_clk_i);
      rdr(32'h18);
      `CHK(rd[12:0], 13'h0000)
      rdr(32'h4);
      `CHK(rd[5:0], 6'h00)
      pin_n <= 1'b1;
      repeat (6) @(posedge sys_clk_i);
      `CHK(r2, 10'h000)
      `CHK(mk, 1'b0)
    end
  endtask

  task conclude;
    begin
      if (err_total == 0 && compares > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // Watchdog well above the expected run of some 5,000 cycles
  initial
  begin
    #4000000;
    err_total++;
    conclude;
  end
  initial
  begin
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    pin_n <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    t_reset;
    t_cmds;
    t_move;
    t_two;
    t_stby;
    t_clkstop;
    t_chop;
    t_pin;
    conclude;
  end
endmodule // tb_top

bind msc_top msc_top_properties chk (.sys_clk_i, .rst_i, .reset_low_pin_i, .enable_pin_i,
  .reference_clock_in_i, .latch_i, .sense_over_i, .bridge_one_fwd_o, .bridge_one_rev_o,
  .bridge_one_oe_o, .bridge_two_fwd_o, .bridge_two_rev_o, .bridge_two_oe_o,
  .phase_marker_out_oe_o, .ref_one_o, .ref_two_o);
